// ===== ivp_pkg.sv
// Constants and types for the interrupt vector placement block.
// Assumes one system clock and fuse levels that are stable while the chip is held in reset.
// Summary of operation
// - Every kind of reset sends the core to the reset entry, vector one, at word address 0x000 or the boot reset address.
// - External requests zero, one and two use vector words 0x002, 0x004 and 0x006.
// - Timer vectors fill words 0x008 to 0x016: timer two compare, overflow, timer one capture, compare A, compare B, overflow, timer zero compare, overflow.
// - Serial peripheral transfer complete sits at 0x018, then USART receive, data empty and transmit complete at 0x01A, 0x01C, 0x01E.
// - Words 0x020 to 0x028 hold converter complete, EEPROM ready, analog comparator, two-wire serial and store-program ready.
// - A programmed boot reset fuse makes reset start at the boot loader entry instead of word zero.
// - A set vector table select moves every interrupt vector, but not the reset entry, to the start of the boot flash section.
// - With the select set, each interrupt vector address is its base table address plus the boot section start.
// - Reset goes to 0x0000 or the boot reset address by the fuse, and the table starts at 0x0002 or boot start plus 0x0002 by the select.
// - The boot reset fuse reads one when unprogrammed and zero when programmed.
// - Slots of never enabled sources are plain program words and get no special treatment.
// - Unused slots in the section that does not hold the active table are plain program words as well.
// - The boot section start address follows the boot size fuses.
// - The vector change unlock clears itself four cycles after it is set, or at once when the select is written.
package ivp_pkg;
	localparam int ivp_src_n = 20;
	localparam int ivp_addr_w = 14;
	localparam int ivp_vnum_w = 5;

	localparam logic [13:0] ivp_reset_addr = 14'h0000;
	localparam logic [13:0] ivp_table_base = 14'h0002;
	localparam logic [4:0]  ivp_reset_vnum = 5'h01;
	localparam logic [4:0]  ivp_first_irq_vnum = 5'h02;

	localparam logic [13:0] ivp_boot_start_sz0 = 14'h3800;
	localparam logic [13:0] ivp_boot_start_sz1 = 14'h3c00;
	localparam logic [13:0] ivp_boot_start_sz2 = 14'h3e00;
	localparam logic [13:0] ivp_boot_start_sz3 = 14'h3f00;

	localparam logic ivp_fuse_programmed = 1'b0;

	localparam int ivp_ctrl_sel_pos = 1;
	localparam int ivp_ctrl_unlock_pos = 0;
	localparam logic ivp_sel_reset = 1'b0;
	localparam logic [2:0] ivp_unlock_cycles = 3'h4;

	localparam logic [4:0]  ivp_vnum_ext0 = 5'h02;
	localparam logic [13:0] ivp_addr_ext0 = 14'h0002;
	localparam logic [4:0]  ivp_vnum_ext2 = 5'h04;
	localparam logic [13:0] ivp_addr_ext2 = 14'h0006;
	localparam logic [4:0]  ivp_vnum_tim2_cmp = 5'h05;
	localparam logic [13:0] ivp_addr_tim2_cmp = 14'h0008;
	localparam logic [4:0]  ivp_vnum_tim0_ovf = 5'h0c;
	localparam logic [13:0] ivp_addr_tim0_ovf = 14'h0016;
	localparam logic [4:0]  ivp_vnum_spi = 5'h0d;
	localparam logic [13:0] ivp_addr_spi = 14'h0018;
	localparam logic [4:0]  ivp_vnum_usart_txc = 5'h10;
	localparam logic [13:0] ivp_addr_usart_txc = 14'h001e;
	localparam logic [4:0]  ivp_vnum_adc = 5'h11;
	localparam logic [13:0] ivp_addr_adc = 14'h0020;
	localparam logic [4:0]  ivp_vnum_spm = 5'h15;
	localparam logic [13:0] ivp_addr_spm = 14'h0028;

	typedef struct packed {
		logic [13:0] addr;
		logic [4:0]  vnum;
		logic        is_reset;
	} ivp_fetch_t;

	typedef enum logic [1:0] {
		IVP_ST_RESET,
		IVP_ST_IDLE,
		IVP_ST_WAIT
	} ivp_state_t;
endpackage

// ===== ivp_vector_place.sv
// Vector fetch address generator between the interrupt sources and the processor core.
// Assumes request lines and control writes come from logic on I_MCLK and fuses are static during reset.
`timescale 1ns/100ps
module ivp_vector_place
	import ivp_pkg::*;
(
	input  wire logic        I_MCLK,
	input  wire logic        I_SRST,
	input  wire logic [19:0] I_IRQ_REQ,
	input  wire logic        I_GLOBAL_IE,
	input  wire logic        I_BOOT_RESET_FUSE,
	input  wire logic [1:0]  I_BOOT_SIZE_FUSES,
	input  wire logic        I_CTRL_WR,
	input  wire logic [1:0]  I_CTRL_WDATA,
	input  wire logic        I_FETCH_ACK,
	output logic             O_FETCH_VALID,
	output logic [13:0]      O_FETCH_ADDR,
	output logic [4:0]       O_FETCH_VNUM,
	output logic             O_FETCH_IS_RESET,
	output logic             O_VECTOR_TABLE_SELECT,
	output logic             O_VECTOR_CHANGE_UNLOCK,
	output logic             O_IRQ_BLOCKED
);
	logic        boot_fuse_r;
	logic        boot_fuse_nxt;
	logic [1:0]  boot_size_r;
	logic [1:0]  boot_size_nxt;
	logic [13:0] boot_start;
	logic        sel_r;
	logic        sel_nxt;
	logic        unlock_r;
	logic        unlock_nxt;
	logic [2:0]  ucnt_r;
	logic [2:0]  ucnt_nxt;
	logic        hold_r;
	logic        hold_nxt;
	logic        blocked_r;
	logic        blocked_nxt;
	ivp_state_t  state_r;
	ivp_state_t  state_nxt;
	ivp_fetch_t  fetch_r;
	ivp_fetch_t  fetch_nxt;
	logic        valid_r;
	logic        valid_nxt;
	logic [4:0]  pick;
	logic [13:0] table_start;
	logic [13:0] reset_target;

	// Fuses are caught while reset is held so a glitch later cannot move the vectors mid-run.
	always_comb begin
		boot_fuse_nxt = boot_fuse_r;
		boot_size_nxt = boot_size_r;
		if (I_SRST) begin
			boot_fuse_nxt = I_BOOT_RESET_FUSE;
			boot_size_nxt = I_BOOT_SIZE_FUSES;
		end
	end

	always_ff @(posedge I_MCLK) begin
		boot_fuse_r <= boot_fuse_nxt;
		boot_size_r <= boot_size_nxt;
	end

	always_comb begin
		case (boot_size_r)
			2'h0:    boot_start = ivp_boot_start_sz0;
			2'h1:    boot_start = ivp_boot_start_sz1;
			2'h2:    boot_start = ivp_boot_start_sz2;
			default: boot_start = ivp_boot_start_sz3;
		endcase
	end

	// Select changes only inside the unlock window; the interrupt gate also covers one cycle after a select write closes it.
	always_comb begin
		sel_nxt    = sel_r;
		unlock_nxt = unlock_r;
		ucnt_nxt   = ucnt_r;
		hold_nxt   = 1'b0;
		if (unlock_r) begin
			ucnt_nxt = ucnt_r - 3'h1;
			if (ucnt_r == 3'h1) begin
				unlock_nxt = 1'b0;
			end
		end
		if (I_CTRL_WR) begin
			if (I_CTRL_WDATA[ivp_ctrl_unlock_pos]) begin
				// A new unlock write wins over the self clear in the same cycle.
				unlock_nxt = 1'b1;
				ucnt_nxt   = ivp_unlock_cycles;
			end else if (unlock_r) begin
				sel_nxt    = I_CTRL_WDATA[ivp_ctrl_sel_pos];
				unlock_nxt = 1'b0;
				ucnt_nxt   = 3'h0;
				hold_nxt   = 1'b1;
			end
		end
		if (I_SRST) begin
			sel_nxt    = ivp_sel_reset;
			unlock_nxt = 1'b0;
			ucnt_nxt   = 3'h0;
			hold_nxt   = 1'b0;
		end
		blocked_nxt = unlock_nxt | hold_nxt;
	end

	always_ff @(posedge I_MCLK) begin
		sel_r     <= sel_nxt;
		unlock_r  <= unlock_nxt;
		ucnt_r    <= ucnt_nxt;
		hold_r    <= hold_nxt;
		blocked_r <= blocked_nxt;
	end

	// Descending scan so the last hit, the lowest source, is the one kept.
	always_comb begin
		pick = 5'h0;
		for (int k = ivp_src_n - 1; k >= 0; k--) begin
			if (I_IRQ_REQ[k]) begin
				pick = 5'(k);
			end
		end
	end

	assign table_start  = sel_r ? boot_start + ivp_table_base : ivp_table_base;
	assign reset_target = (boot_fuse_r == ivp_fuse_programmed) ? boot_start : ivp_reset_addr;

	// Addresses are plain word addresses; whatever code sits in an unused slot is fetched like any other.
	always_comb begin
		state_nxt = state_r;
		fetch_nxt = fetch_r;
		valid_nxt = valid_r;
		case (state_r)
			IVP_ST_RESET: begin
				fetch_nxt.addr     = reset_target;
				fetch_nxt.vnum     = ivp_reset_vnum;
				fetch_nxt.is_reset = 1'b1;
				valid_nxt          = 1'b1;
				state_nxt          = IVP_ST_WAIT;
			end
			IVP_ST_IDLE: begin
				if ((|I_IRQ_REQ) && I_GLOBAL_IE && !blocked_r) begin
					// Slot for source k is two words per vector past the table start.
					fetch_nxt.addr     = table_start + {8'h0, pick, 1'b0};
					fetch_nxt.vnum     = pick + ivp_first_irq_vnum;
					fetch_nxt.is_reset = 1'b0;
					valid_nxt          = 1'b1;
					state_nxt          = IVP_ST_WAIT;
				end
			end
			IVP_ST_WAIT: begin
				if (I_FETCH_ACK) begin
					valid_nxt = 1'b0;
					state_nxt = IVP_ST_IDLE;
				end
			end
			default: begin
				valid_nxt = 1'b0;
				state_nxt = IVP_ST_IDLE;
			end
		endcase
		if (I_SRST) begin
			state_nxt = IVP_ST_RESET;
			fetch_nxt = '0;
			valid_nxt = 1'b0;
		end
	end

	always_ff @(posedge I_MCLK) begin
		state_r <= state_nxt;
		fetch_r <= fetch_nxt;
		valid_r <= valid_nxt;
	end

	assign O_FETCH_VALID          = valid_r;
	assign O_FETCH_ADDR           = fetch_r.addr;
	assign O_FETCH_VNUM           = fetch_r.vnum;
	assign O_FETCH_IS_RESET       = fetch_r.is_reset;
	assign O_VECTOR_TABLE_SELECT  = sel_r;
	assign O_VECTOR_CHANGE_UNLOCK = unlock_r;
	assign O_IRQ_BLOCKED          = blocked_r;

	default clocking cb @(posedge I_MCLK); endclocking
	default disable iff (I_SRST);

	reset_entry_a: assert property (
		$rose(valid_r) && fetch_r.is_reset |->
		fetch_r.addr == ((boot_fuse_r == ivp_fuse_programmed) ? boot_start : ivp_reset_addr)
	) else $error("Reset entry address wrong.");

	ext_slot_a: assert property (
		valid_r && !fetch_r.is_reset && !sel_r && fetch_r.vnum == ivp_vnum_ext2 |-> fetch_r.addr == ivp_addr_ext2
	) else $error("External request slot wrong.");

	timer_slot_a: assert property (
		valid_r && !fetch_r.is_reset && !sel_r && fetch_r.vnum == ivp_vnum_tim0_ovf |->
		fetch_r.addr == ivp_addr_tim0_ovf
	) else $error("Timer slot wrong.");

	serial_slot_a: assert property (
		valid_r && !fetch_r.is_reset && !sel_r && fetch_r.vnum == ivp_vnum_usart_txc |->
		fetch_r.addr == ivp_addr_usart_txc
	) else $error("Serial slot wrong.");

	last_slot_a: assert property (
		valid_r && !fetch_r.is_reset && !sel_r && fetch_r.vnum == ivp_vnum_spm |-> fetch_r.addr == ivp_addr_spm
	) else $error("Store program slot wrong.");

	boot_reloc_a: assert property (
		valid_r && !fetch_r.is_reset && sel_r |->
		fetch_r.addr == boot_start + {8'h0, fetch_r.vnum - ivp_reset_vnum, 1'b0}
	) else $error("Relocated vector address wrong.");

	unlock_expire_a: assert property (
		$rose(unlock_r) && !I_CTRL_WR ##1 !I_CTRL_WR[*3] |-> unlock_r ##1 !unlock_r
	) else $error("Unlock did not expire after four cycles.");

	select_write_a: assert property (
		I_CTRL_WR && unlock_r && !I_CTRL_WDATA[ivp_ctrl_unlock_pos] |=>
		!unlock_r && sel_r == $past(I_CTRL_WDATA[ivp_ctrl_sel_pos]) && blocked_r
	) else $error("Select write not taken.");

	lowest_first_a: assert property (
		$rose(valid_r) && !fetch_r.is_reset |->
		($past(I_IRQ_REQ) & ((20'h1 << (fetch_r.vnum - ivp_first_irq_vnum)) - 20'h1)) == 20'h0
	) else $error("Lower pending request skipped.");

	gate_block_a: assert property (
		$rose(valid_r) && !fetch_r.is_reset |-> !$past(blocked_r) && $past(I_GLOBAL_IE)
	) else $error("Vector issued while blocked.");
endmodule

// ===== ivp_core_model.sv
// Processor core model that acknowledges vector fetches after a chosen wait.
// Assumes the fetch outputs of the vector placement block and the shared I_MCLK.
`timescale 1ns/100ps
module ivp_core_model (
	input  wire logic       i_clk,
	input  wire logic       i_valid,
	input  wire logic [3:0] i_wait,
	output logic            o_ack
);
	logic [3:0] cnt_r;
	initial begin
		o_ack = 1'b0;
		cnt_r = 4'h0;
	end
	// Updates land on the falling edge so the acknowledge is settled at every rising edge.
	always @(negedge i_clk) begin
		if (i_valid !== 1'b1) begin
			cnt_r <= 4'h0;
			o_ack <= 1'b0;
		end else begin
			cnt_r <= cnt_r + 4'h1;
			o_ack <= (cnt_r >= i_wait);
		end
	end
endmodule

// ===== tb.sv
// Self-checking bench for the vector placement block with a core model on the fetch side.
// Assumes the block and the core model are compiled before this file.
`timescale 1ns/100ps
module tb;
	import ivp_pkg::*;
	logic        mclk = 1'b0;
	logic        srst = 1'b1;
	logic [19:0] req = 20'h0;
	logic        ie = 1'b0;
	logic        rfuse = 1'b1;
	logic [1:0]  szf = 2'h0;
	logic        wr = 1'b0;
	logic [1:0]  wd = 2'h0;
	logic [3:0]  wt = 4'h0;
	logic        ack, valid, is_rst, sel, unl, blk;
	logic [13:0] f_addr;
	logic [4:0]  f_vnum;
	int          mismatches = 0;
	int          compares = 0;
	always #5 mclk = ~mclk;
	ivp_vector_place uut (.I_MCLK(mclk), .I_SRST(srst), .I_IRQ_REQ(req), .I_GLOBAL_IE(ie),
		.I_BOOT_RESET_FUSE(rfuse), .I_BOOT_SIZE_FUSES(szf), .I_CTRL_WR(wr), .I_CTRL_WDATA(wd),
		.I_FETCH_ACK(ack), .O_FETCH_VALID(valid), .O_FETCH_ADDR(f_addr), .O_FETCH_VNUM(f_vnum),
		.O_FETCH_IS_RESET(is_rst), .O_VECTOR_TABLE_SELECT(sel), .O_VECTOR_CHANGE_UNLOCK(unl),
		.O_IRQ_BLOCKED(blk));
	ivp_core_model core (.i_clk(mclk), .i_valid(valid), .i_wait(wt), .o_ack(ack));
	function automatic logic [13:0] boot(input logic [1:0] s);
		case (s)
			2'h0: return 14'h3800;
			2'h1: return 14'h3c00;
			2'h2: return 14'h3e00;
			default: return 14'h3f00;
		endcase
	endfunction
	task automatic chk(input string name, input logic [13:0] seen, input logic [13:0] exp);
		compares++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic fetch(input logic [13:0] addr, input logic [4:0] vnum, input logic rst);
		int n;
		n = 0;
		while (valid !== 1'b1 && n < 20) begin
			@(negedge mclk);
			n++;
		end
		req = 20'h0;
		chk("valid", {13'h0, valid}, 14'h1);
		chk("addr", f_addr, addr);
		chk("vnum", {9'h0, f_vnum}, {9'h0, vnum});
		chk("is_reset", {13'h0, is_rst}, {13'h0, rst});
		n = 0;
		while (valid !== 1'b0 && n < 20) begin
			@(negedge mclk);
			n++;
		end
	endtask
	task automatic do_reset(input logic fuse, input logic [1:0] sz);
		srst = 1'b1;
		rfuse = fuse;
		szf = sz;
		repeat (3) @(negedge mclk);
		srst = 1'b0;
		@(negedge mclk);
	endtask
	task automatic ctrl(input logic [1:0] d);
		wr = 1'b1;
		wd = d;
		@(negedge mclk);
		wr = 1'b0;
		@(negedge mclk);
	endtask
	task automatic t_reset;
		for (int f = 0; f < 2; f++) begin
			for (int s = 0; s < 4; s++) begin
				do_reset(f[0], s[1:0]);
				fetch(f[0] ? 14'h0000 : boot(s[1:0]), 5'h01, 1'b1);
			end
		end
	endtask
	task automatic t_vectors(input logic [13:0] base);
		for (int i = 0; i < 20; i++) begin
			req[i] = 1'b1;
			fetch(base + 14'(2 * i), 5'(i + 2), 1'b0);
			@(negedge mclk);
		end
		req = 20'hc0408;
		fetch(base + 14'h0006, 5'h05, 1'b0);
	endtask
	// A pending request must wait while interrupts are off and while the unlock window is open.
	task automatic t_gate;
		ie = 1'b0;
		req = 20'h00010;
		repeat (4) @(negedge mclk);
		chk("ie_gate", {13'h0, valid}, 14'h0);
		ie = 1'b1;
		fetch(14'h000a, 5'h06, 1'b0);
		@(negedge mclk);
		ctrl(2'h1);
		req = 20'h00010;
		chk("blk_gate_on", {13'h0, blk}, 14'h1);
		repeat (2) @(negedge mclk);
		chk("blk_gate", {13'h0, valid}, 14'h0);
		fetch(14'h000a, 5'h06, 1'b0);
	endtask
	task automatic t_select;
		int n;
		ctrl(2'h2);
		chk("sel_locked", {13'h0, sel}, 14'h0);
		ctrl(2'h1);
		chk("blocked", {13'h0, blk}, 14'h1);
		// One cycle of the window has passed when ctrl returns.
		n = 0;
		repeat (6) begin
			if (unl === 1'b1) n++;
			@(negedge mclk);
		end
		chk("unlock_len", 14'(n), 14'h3);
		ctrl(2'h1);
		ctrl(2'h2);
		chk("sel_set", {13'h0, sel}, 14'h1);
		chk("unlock_clr", {13'h0, unl}, 14'h0);
		wt = 4'h5;
		t_vectors(boot(2'h2) + 14'h0002);
		wt = 4'h0;
	endtask
	task automatic test_done;
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// The full run needs under five hundred cycles, so twenty thousand means a hang.
	initial begin
		#200000;
		mismatches++;
		test_done();
	end
	initial begin
		ie = 1'b1;
		t_reset();
		do_reset(1'b1, 2'h2);
		fetch(14'h0000, 5'h01, 1'b1);
		t_vectors(14'h0002);
		t_gate();
		t_select();
		test_done();
	end
endmodule
